// [design/dlp_pkg.sv]
// package: constants, state and pin types for the low-power state control block
package dlp_pkg;
  // register byte offsets on the wishbone slave
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_EXITLAT  = 8'h04;
  localparam logic [7:0] OFS_XSNR     = 8'h08;
  // status field positions
  localparam int STS_STATE_LSB = 0;
  localparam int STS_DLL       = 3;
  localparam int STS_READY     = 4;
  localparam int STS_SLOW      = 5;
  localparam int STS_HITEMP    = 6;
  localparam int STS_DROP      = 7;
  // exit latency field positions (cycles)
  localparam int EXL_XP_LSB    = 0;
  localparam int EXL_XARD_LSB  = 8;
  localparam int EXL_XARDS_LSB = 16;
  // reset values of the latency registers, in cycles
  localparam logic [7:0]  RST_XP    = 8'h02;
  localparam logic [7:0]  RST_XARD  = 8'h02;
  localparam logic [7:0]  RST_XARDS = 8'h08;
  localparam logic [15:0] RST_XSNR  = 16'h000a;
  // clock and refresh interval of the high temperature range
  localparam int CLK_PERIOD_NS   = 20;
  localparam int T_REFI_HT_NS    = 3900;
  localparam int REFI_HT_CYC     = T_REFI_HT_NS / CLK_PERIOD_NS;
  localparam int REFI_NORMAL_CYC = 2 * REFI_HT_CYC;
  localparam int REF_CNT_W       = 10;
  // mode register bank selects
  localparam logic [2:0] BA_MR   = 3'h0;
  localparam logic [2:0] BA_EMR2 = 3'h2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PPD,
    ST_APD_FAST,
    ST_APD_SLOW,
    ST_SREF,
    ST_EXIT,
    ST_LOST
  } dlp_state_t;

  // command and control pins sampled at the rising edge
  typedef struct packed {
    logic       cke;
    logic       cs_n;
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
    logic       odt;
    logic [2:0] ba;
    logic       a12;
    logic       a7;
  } dlp_pins_t;
endpackage

// [design/dlp_ctrl.sv]
// low-power state control: self refresh, power-down, idle commands, wishbone registers
// How it works
// [R1] cke falling with cs, ras, cas low and we high enters self refresh
// [R2] controller turns termination off before self refresh entry
// [R3] in self refresh only cke matters; cke low keeps the state
// [R4] dll turns off on self refresh entry and back on at exit
// [R5] self refresh starts a refresh at once, repeats on timer, gates clock
// [R6] controller restores clock first, then sends only nop/deselect for exit delay
// [R7] controller keeps cke high and termination off during exit-to-read period
// [R8] controller waits and gives one extra refresh before self refresh re-entry
// [R9] cke falling with nop or deselect enters power-down
// [R10] power-down entry is accepted while row, precharge, mode or refresh work runs
// [R11] controller enters power-down with dll locked, else resets it after
// [R12] all banks closed gives precharge power-down, an open row active power-down
// [R13] mode register a12 picks fast or slow active power-down exit
// [R14] power-down cuts buffers; dll off except in fast active power-down
// [R15] controller holds cke low, clock stable, stays at most 9 refresh intervals
// [R16] cke high exits power-down; commands wait the mode's exit latency
// [R17] unexpected cke drop loses array contents; full re-initialization needed
// [R18] controller changes clock only in precharge power-down, 2 clocks after cke low
// [R19] after a clock change controller resets dll and may reprogram latencies
// [R20] controller holds odt and cke low while the clock changes and relocks
// [R21] nop is cs low with ras, cas, we high; it disturbs nothing
// [R22] cs high is deselect and acts exactly like nop
// [R23] extended mode register 2 bit a7 doubles the self refresh rate
// [R24] auto refresh is cs, ras, cas low, we high with cke staying high
// [R25] controller waits refresh cycle time after a refresh command
//
// The register offsets and the Wishbone slave port were decided locally.
module dlp_ctrl
  import dlp_pkg::*;
#(
  parameter int REFI_HT  = REFI_HT_CYC,
  parameter int REFI_NOR = REFI_NORMAL_CYC
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire dlp_pkg::dlp_pins_t   pins_i,
  input  wire logic                 bank_open_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  output dlp_pkg::dlp_state_t       state_o,
  output logic                      dll_en_o,
  output logic                      buf_en_o,
  output logic                      int_clk_en_o,
  output logic                      ref_pulse_o,
  output logic                      cmd_ready_o
);
  import dlp_pkg::*;

  dlp_state_t           state_r, state_nxt;
  logic                 cke_q_r;
  logic [15:0]          exit_cnt_r, exit_cnt_nxt;
  logic [REF_CNT_W-1:0] ref_cnt_r;
  logic                 slow_r, hitemp_r, drop_r;
  logic [23:0]          exl_r;
  logic [15:0]          xsnr_r;

  // command decode; deselect and nop collapse into one idle term
  wire cmd_des     = pins_i.cs_n;                                                  // see [R22]
  wire cmd_nop     = !pins_i.cs_n && pins_i.ras_n && pins_i.cas_n && pins_i.we_n;  // see [R21]
  wire cmd_idle    = cmd_des || cmd_nop;
  wire cmd_ref     = !pins_i.cs_n && !pins_i.ras_n && !pins_i.cas_n && pins_i.we_n;
  wire cmd_mrs     = !pins_i.cs_n && !pins_i.ras_n && !pins_i.cas_n && !pins_i.we_n;
  wire cke_fall    = cke_q_r && !pins_i.cke;
  wire cke_hold    = cke_q_r && pins_i.cke;
  wire in_idle     = state_r == ST_IDLE;
  wire sref_enter  = in_idle && cke_fall && cmd_ref;                               // see [R1]
  wire pd_enter    = in_idle && cke_fall && cmd_idle;                              // see [R9] [R10]
  wire auto_ref    = in_idle && cke_hold && cmd_ref;                               // see [R24]
  wire mrs_take    = in_idle && cke_hold && cmd_mrs;
  wire bad_drop    = (in_idle || state_r == ST_EXIT) && cke_fall && !sref_enter && !pd_enter; // see [R17]
  wire low_power   = state_r inside {ST_PPD, ST_APD_FAST, ST_APD_SLOW, ST_SREF};
  wire wake        = low_power && pins_i.cke;                                      // see [R16]

  // exit latency for the mode being left
  logic [15:0] exit_load;
  always_comb begin
    unique case (state_r)
      ST_PPD:      exit_load = {8'h00, exl_r[EXL_XP_LSB +: 8]};
      ST_APD_FAST: exit_load = {8'h00, exl_r[EXL_XARD_LSB +: 8]};                  // see [R13]
      ST_APD_SLOW: exit_load = {8'h00, exl_r[EXL_XARDS_LSB +: 8]};                 // see [R13]
      default:     exit_load = xsnr_r;
    endcase
  end

  // next state; in self refresh every pin but cke is ignored
  always_comb begin
    state_nxt    = state_r;
    exit_cnt_nxt = exit_cnt_r;
    unique case (state_r)
      ST_IDLE: begin
        if (sref_enter)
          state_nxt = ST_SREF;
        else if (pd_enter)
          state_nxt = !bank_open_i ? ST_PPD : (slow_r ? ST_APD_SLOW : ST_APD_FAST); // see [R12] [R13]
        else if (bad_drop)
          state_nxt = ST_LOST;
      end
      ST_PPD, ST_APD_FAST, ST_APD_SLOW, ST_SREF: begin
        if (wake) begin                                                            // see [R3]
          state_nxt    = ST_EXIT;
          exit_cnt_nxt = (exit_load == 16'h0000) ? 16'h0001 : exit_load;
        end
      end
      ST_EXIT: begin
        if (bad_drop)
          state_nxt = ST_LOST;
        else if (exit_cnt_r <= 16'h0001)
          state_nxt = ST_IDLE;
        else
          exit_cnt_nxt = exit_cnt_r - 16'h0001;
      end
      ST_LOST: begin
        // contents are gone; a mode register write during re-init brings it back
        if (pins_i.cke && cmd_mrs && pins_i.ba == BA_MR)
          state_nxt = ST_IDLE;
      end
    endcase
  end

  // state and output flops, outputs follow the next state so they align with state_o
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r      <= ST_IDLE;
      cke_q_r      <= 1'b0;
      exit_cnt_r   <= 16'h0000;
      dll_en_o     <= 1'b1;
      buf_en_o     <= 1'b1;
      int_clk_en_o <= 1'b1;
      cmd_ready_o  <= 1'b1;
    end else begin
      state_r      <= state_nxt;
      cke_q_r      <= pins_i.cke;
      exit_cnt_r   <= exit_cnt_nxt;
      dll_en_o     <= !(state_nxt inside {ST_SREF, ST_PPD, ST_APD_SLOW});           // see [R4] [R14]
      buf_en_o     <= !(state_nxt inside {ST_SREF, ST_PPD, ST_APD_FAST, ST_APD_SLOW}); // see [R14]
      int_clk_en_o <= state_nxt != ST_SREF;                                        // see [R5]
      cmd_ready_o  <= state_nxt == ST_IDLE;                                        // see [R16]
    end
  end
  assign state_o = state_r;

  // self refresh timer: first refresh right after entry, then every interval;
  // the high temperature option halves the interval
  wire [REF_CNT_W-1:0] ref_period = hitemp_r ? REF_CNT_W'(REFI_HT - 1) : REF_CNT_W'(REFI_NOR - 1); // see [R23]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_cnt_r   <= '0;
      ref_pulse_o <= 1'b0;
    end else begin
      ref_pulse_o <= auto_ref || (state_r == ST_SREF && ref_cnt_r == '0);          // see [R5] [R24]
      if (state_r != ST_SREF || ref_cnt_r == '0)
        ref_cnt_r <= (state_r == ST_SREF) ? ref_period : '0;
      else
        ref_cnt_r <= ref_cnt_r - REF_CNT_W'(1);
    end
  end

  // mode bits latched from mode register commands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slow_r   <= 1'b0;
      hitemp_r <= 1'b0;
    end else if (mrs_take) begin
      if (pins_i.ba == BA_MR)
        slow_r <= pins_i.a12;                                                      // see [R13]
      if (pins_i.ba == BA_EMR2)
        hitemp_r <= pins_i.a7;                                                     // see [R23]
    end
  end

  // wishbone slave: one wait state, unmapped reads return zero, writes ignored
  wire        wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        wb_wr     = wb_req && wb_we_i;
  wire [31:0] wb_mask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire        drop_clr  = wb_wr && wb_adr_i == OFS_STATUS && wb_sel_i[0] && wb_dat_i[STS_DROP];
  wire [31:0] sts_word  = {24'h000000, drop_r, hitemp_r, slow_r, cmd_ready_o, dll_en_o, state_r};
  wire [31:0] rd_word   = (wb_adr_i == OFS_STATUS)  ? sts_word :
                          (wb_adr_i == OFS_EXITLAT) ? {8'h00, exl_r} :
                          (wb_adr_i == OFS_XSNR)    ? {16'h0000, xsnr_r} : 32'h00000000;
  wire [31:0] exl_wr    = ({8'h00, exl_r} & ~wb_mask) | (wb_dat_i & wb_mask);
  wire [31:0] xsnr_wr   = ({16'h0000, xsnr_r} & ~wb_mask) | (wb_dat_i & wb_mask);

  // register flops; a drop in the clearing cycle keeps the flag set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      exl_r    <= {RST_XARDS, RST_XARD, RST_XP};
      xsnr_r   <= RST_XSNR;
      drop_r   <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_word : 32'h00000000;
      if (wb_wr && wb_adr_i == OFS_EXITLAT)
        exl_r <= exl_wr[23:0];
      if (wb_wr && wb_adr_i == OFS_XSNR)
        xsnr_r <= xsnr_wr[15:0];
      drop_r <= (state_nxt == ST_LOST && state_r != ST_LOST) || (drop_r && !drop_clr); // see [R17]
    end
  end

  // checks
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_sref_entry: assert property (sref_enter |=> state_r == ST_SREF && !int_clk_en_o) // see [R1]
    else $error("self refresh entry not taken");
  a_sref_hold: assert property (state_r == ST_SREF && !pins_i.cke |=> state_r == ST_SREF) // see [R3]
    else $error("self refresh left while cke low");
  a_sref_dll: assert property ($fell(state_r == ST_SREF) |-> dll_en_o && !$past(dll_en_o)) // see [R4]
    else $error("dll not toggled around self refresh");
  a_sref_first_ref: assert property ($rose(state_r == ST_SREF) |=> ref_pulse_o) // see [R5]
    else $error("no refresh right after self refresh entry");
  a_pd_kind: assert property (pd_enter |=> state_r == (!$past(bank_open_i) ? ST_PPD :
      ($past(slow_r) ? ST_APD_SLOW : ST_APD_FAST))) // see [R9] [R12] [R13]
    else $error("wrong power-down kind");
  a_pd_buffers: assert property (state_r inside {ST_PPD, ST_APD_FAST, ST_APD_SLOW} |->
      !buf_en_o && (dll_en_o == (state_r == ST_APD_FAST))) // see [R14]
    else $error("power-down buffers or dll wrong");
  a_exit_wait: assert property (wake |=> !cmd_ready_o && exit_cnt_r == (($past(exit_load) == 16'h0000) ?
      16'h0001 : $past(exit_load))) // see [R16]
    else $error("exit latency not loaded");
  a_exit_done: assert property (state_r == ST_EXIT && exit_cnt_r == 16'h0001 && !bad_drop |=>
      state_r == ST_IDLE && cmd_ready_o) // see [R16]
    else $error("exit latency overrun");
  a_nop_quiet: assert property (in_idle && cke_hold && cmd_idle |=> state_r == ST_IDLE) // see [R21] [R22]
    else $error("nop or deselect changed state");
  a_drop_lost: assert property (bad_drop |=> state_r == ST_LOST && drop_r) // see [R17]
    else $error("unexpected cke drop not flagged");
  a_hitemp_rate: assert property (ref_pulse_o && state_r == ST_SREF && hitemp_r |->
      ref_cnt_r == REF_CNT_W'(REFI_HT - 1)) // see [R23]
    else $error("self refresh interval wrong");

  // automatic refresh from idle pulses once and leaves the state alone
  a_auto_ref: assert property (auto_ref |=> ref_pulse_o && state_r == ST_IDLE) // see [R24]
    else $error("auto refresh not started");

  // in self refresh everything that burns power is off
  a_sref_outs: assert property (state_r == ST_SREF |-> !dll_en_o && !buf_en_o && !int_clk_en_o && !cmd_ready_o) // see [R5]
    else $error("self refresh outputs wrong");

  // the internal clock comes back as soon as self refresh is left
  a_sref_clk_back: assert property ($fell(state_r == ST_SREF) |-> int_clk_en_o) // see [R5]
    else $error("internal clock not restored");

  // internal refreshes never run back to back, the timer reloads first
  a_ref_spacing: assert property (ref_pulse_o && state_r == ST_SREF |=> !ref_pulse_o) // see [R5]
    else $error("self refresh pulses too close");

  // power-down is kept while cke stays low, whatever else the pins do
  a_pd_stay: assert property (state_r inside {ST_PPD, ST_APD_FAST, ST_APD_SLOW} && !pins_i.cke |=>
      state_r == $past(state_r)) // see [R9]
    else $error("power-down left while cke low");

  // no refresh activity while in power-down
  a_pd_no_ref: assert property (state_r inside {ST_PPD, ST_APD_FAST, ST_APD_SLOW} |-> !ref_pulse_o) // see [R14]
    else $error("refresh pulse in power-down");

  // waking turns buffers and dll back on together with the exit state
  a_wake_on: assert property (wake |=> state_r == ST_EXIT && buf_en_o && dll_en_o) // see [R4] [R16]
    else $error("wake did not restore buffers");

  // exit counter steps down by one each cycle until it ends
  a_exit_count: assert property (state_r == ST_EXIT && exit_cnt_r > 16'h0001 && !bad_drop |=>
      state_r == ST_EXIT && exit_cnt_r == $past(exit_cnt_r) - 16'h0001) // see [R16]
    else $error("exit counter step wrong");

  // ready mirrors the idle state at all times
  a_ready_idle: assert property (cmd_ready_o == (state_r == ST_IDLE)) // see [R16]
    else $error("ready out of step with state");

  // lost contents stay lost until a mode register write
  a_lost_hold: assert property (state_r == ST_LOST && !(pins_i.cke && cmd_mrs && pins_i.ba == BA_MR) |=>
      state_r == ST_LOST) // see [R17]
    else $error("lost state left without re-init");

  // drop flag is sticky until software clears it
  a_drop_sticky: assert property (drop_r && !drop_clr |=> drop_r) // see [R17]
    else $error("drop flag lost");

  // a12 of a mode register write picks the active power-down variant
  a_slow_latch: assert property (mrs_take && pins_i.ba == BA_MR |=> slow_r == $past(pins_i.a12)) // see [R13]
    else $error("slow exit bit not latched");

  // a7 of the second extended mode register picks the high temperature rate
  a_hitemp_latch: assert property (mrs_take && pins_i.ba == BA_EMR2 |=> hitemp_r == $past(pins_i.a7)) // see [R23]
    else $error("high temperature bit not latched");

  // ack is a single cycle pulse, never stretched
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");

  // a nop or deselect in power-down never wakes the device on its own
  a_pd_idle_cmd: assert property (low_power && !pins_i.cke && cmd_idle |=> state_r != ST_EXIT) // see [R21] [R22]
    else $error("idle command woke the device");

  c_sref: cover property (sref_enter ##[1:20] state_r == ST_EXIT);
  c_apd_slow: cover property (state_r == ST_APD_SLOW ##1 state_r == ST_EXIT);
  c_lost: cover property (bad_drop);
  c_apd_fast: cover property (state_r == ST_APD_FAST ##1 state_r == ST_EXIT);
  c_exit_done: cover property (state_r == ST_EXIT ##1 state_r == ST_IDLE);
endmodule

// [test/dlp_host_model.sv]
// controller-side partner: drives command pins, clock enable and termination
module dlp_host_model (
  input  wire logic          clk_i,
  output dlp_pkg::dlp_pins_t pins_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import dlp_pkg::*;

  // start deselected with cke high and termination off
  initial pins_o = {1'b1, 4'b1111, 1'b0, 3'h0, 1'b0, 1'b0};

  // one command at the next edge, odt kept low; entries only from idle with dll on
  task automatic cmd(input logic k, input logic [3:0] c, input logic [2:0] b, input logic s, input logic t);
    @(posedge clk_i);
    pins_o <= {k, c, 1'b0, b, s, t};
  endtask

  // low-power stay: cke, odt, a12 and a7 low, cs high; ras, cas, we and ba wander since the device ignores them
  task automatic hold_low(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      pins_o <= {1'b0, 1'b1, 3'(i), 1'b0, 3'(~i), 1'b0, 1'b0};
    end
  endtask

  // exit: clock already runs, cke rises with nop and stays high with nop
  task automatic leave();
    @(posedge clk_i);
    pins_o <= {1'b1, 4'b0111, 1'b0, 3'h0, 1'b0, 1'b0};
  endtask
endmodule

// [test/testbench.sv]
// self-checking bench: power-down, self refresh, refresh, cke drop and registers
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import dlp_pkg::*;

  localparam int RH = 4;
  localparam int RN = 8;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        bank_open_i = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic [31:0] seed = 32'h249a;
  logic        wb_ack_o, dll_en_o, buf_en_o, int_clk_en_o, ref_pulse_o, cmd_ready_o;
  dlp_pins_t   pins;
  dlp_state_t  state_o;
  int          failures = 0;
  int          total_checks = 0;
  int          n, xs, m;

  // 50 MHz clock
  always #10 clk_i = ~clk_i;

  dlp_ctrl #(.REFI_HT(RH), .REFI_NOR(RN)) dlp_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .pins_i(pins),
    .bank_open_i(bank_open_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .state_o(state_o), .dll_en_o(dll_en_o), .buf_en_o(buf_en_o),
    .int_clk_en_o(int_clk_en_o), .ref_pulse_o(ref_pulse_o), .cmd_ready_o(cmd_ready_o));
  dlp_host_model dlp_host_model_i (.clk_i(clk_i), .pins_o(pins));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // reference model: power-down flavour and its exit latency
  function automatic dlp_state_t pd_st(logic b, logic s);
    return b ? (s ? ST_APD_SLOW : ST_APD_FAST) : ST_PPD;
  endfunction
  function automatic int pd_lat(logic b, logic s);
    return b ? (s ? RST_XARDS : RST_XARD) : RST_XP;
  endfunction
  task automatic chk_v(string w, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chk_st(string w, dlp_state_t e);
    total_checks++;
    if (state_o !== e) begin
      failures++;
      $display("Error %s expected %0d seen %0d", w, e, state_o);
    end
  endtask
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask
  // classic single cycle; waits for ack however long it takes
  task automatic wb(logic we, logic [7:0] a, logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic leave_chk(int lat);
    dlp_host_model_i.leave();
    tick();
    chk_st("exit", ST_EXIT);
    n = 0;
    while (cmd_ready_o !== 1'b1 && n < 300) begin
      tick();
      n++;
    end
    chk_v("exit latency", 1, 32'(n >= lat - 1 && n <= lat + 1));
  endtask
  task automatic results();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk_i);
    failures++;
    $display("Error watchdog expected done seen hang");
    results();
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    tick();
    chk_st("reset state", ST_IDLE);
    chk_v("reset outs", 5'h1f, {dll_en_o, buf_en_o, int_clk_en_o, cmd_ready_o, ~ref_pulse_o});
    wb(1'b0, OFS_EXITLAT, 32'h0);
    chk_v("exitlat", {8'h00, RST_XARDS, RST_XARD, RST_XP}, rd);
    wb(1'b0, 8'hfc, 32'h0);
    chk_v("unmapped", 32'h0, rd);
    xs = 2 + rnd() % 8;
    wb(1'b1, OFS_XSNR, 32'(xs));
    wb(1'b0, OFS_XSNR, 32'h0);
    chk_v("xsnr", 32'(xs), rd);
    // precharge, fast active, slow active power-down; nop or random deselect entry
    for (m = 0; m < 3; m++) begin
      dlp_host_model_i.cmd(1'b1, 4'b0000, BA_MR, m == 2, 1'b0);
      bank_open_i <= (m > 0);
      n = rnd();
      dlp_host_model_i.cmd(1'b0, m[0] ? {1'b1, n[2:0]} : 4'b0111, BA_MR, 1'b0, 1'b0);
      tick();
      chk_st("pd entry", pd_st(m > 0, m == 2));
      chk_v("pd dll buf", {m == 1, 1'b0}, {dll_en_o, buf_en_o});
      dlp_host_model_i.hold_low(3);
      leave_chk(pd_lat(m > 0, m == 2));
    end
    bank_open_i <= 1'b0;
    dlp_host_model_i.cmd(1'b1, 4'b0001, BA_MR, 1'b0, 1'b0);
    dlp_host_model_i.cmd(1'b1, 4'b0111, BA_MR, 1'b0, 1'b0);
    #1;
    chk_v("auto refresh", 1, ref_pulse_o);
    chk_st("nop idle", ST_IDLE);
    dlp_host_model_i.cmd(1'b1, 4'b0000, BA_EMR2, 1'b0, 1'b1);
    dlp_host_model_i.cmd(1'b0, 4'b0001, BA_MR, 1'b0, 1'b0);
    tick();
    chk_st("sref entry", ST_SREF);
    chk_v("sref outs", 4'h0, {dll_en_o, buf_en_o, int_clk_en_o, cmd_ready_o});
    n = 0;
    while (ref_pulse_o !== 1'b1 && n < RN) begin
      tick();
      n++;
    end
    chk_v("sref refresh", 1, ref_pulse_o);
    dlp_host_model_i.hold_low(2 * RH);
    leave_chk(xs);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk_v("status", 32'h78, rd);
    // read command with cke falling is an unexpected drop
    dlp_host_model_i.cmd(1'b0, 4'b0101, BA_MR, 1'b0, 1'b0);
    tick();
    chk_st("cke drop", ST_LOST);
    dlp_host_model_i.leave();
    dlp_host_model_i.cmd(1'b1, 4'b0000, BA_MR, 1'b0, 1'b0);
    dlp_host_model_i.cmd(1'b1, 4'b0111, BA_MR, 1'b0, 1'b0);
    n = 0;
    while (cmd_ready_o !== 1'b1 && n < 30) begin
      tick();
      n++;
    end
    chk_st("reinit", ST_IDLE);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk_v("drop flag", 32'hf8, rd);
    wb(1'b1, OFS_STATUS, 32'h80);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk_v("drop cleared", 32'h78, rd);
    results();
  end
endmodule
